/* rtl/ptp_system_time_pps.sv */
// System time counter with load, adjust, target compare and pulse output.
// --------------------
// Summary of operation
// [RULE1] Simple mode gives fixed pulse frequencies.
// [RULE2] Single setting: one-clock pulse each second.
// [RULE3] 1 Hz square, not in binary wrap.
// [RULE4] 2 Hz to 16384 Hz in both modes; decimal wrap here stops at 8192 Hz.
// [RULE5] Top 32 kHz setting binary wrap only; here the top setting gives 16384 Hz.
// [RULE6] Binary wrap gives even duty cycle.
// [RULE7] Decimal wrap averages frequency, realigned each second.
// [RULE8] Software reads seconds and subseconds.
// [RULE9] Decimal wrap: subsecond step one nanosecond.
// [RULE10] Binary wrap: subsecond step about 0.46 ns.
// [RULE11] Software may load the time outright.
// [RULE12] Adjust adds or subtracts by direction flag.
// [RULE13] Target interrupt on first increment reaching target.
// [RULE14] Disabling target interrupt cancels pending one.
// [RULE15] Status read returns and clears flags.
// [RULE16] Coarse tick per clock, fine on overflow.
// [RULE17] Target usage: interrupt, command, or both.
// [RULE18] Subseconds wrap at rollover, seconds increment.
// --------------------
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
module ptp_system_time_pps (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Register port.
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [31:0]      regRdData,
    // Event outputs.
    output logic             timeEventIrq,
    output logic             targetCmdTrigger,
    // Pulse pin.
    output logic             ppsOut
);
    import ptp_time_pkg::*;

    // --------------------
    // Reset release.
    // --------------------
    logic rstMeta_q;   // First stage, read only by the second.
    logic rstSync_b;   // Released reset used everywhere else.

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_b <= rstMeta_q;
        end
    end

    // --------------------
    // Software registers.
    // --------------------
    logic [31:0] control_q;     // Mode, frequency, usage and enable.
    sys_time_t   operand_q;     // Load or adjust operand.
    sys_time_t   target_q;      // Target time.
    logic [31:0] subInc_q;      // Subsecond increment per tick.
    logic [31:0] addend_q;      // Fine update addend.
    logic        armed_q;       // Target interrupt armed.
    logic        wrapFlag_q;    // Seconds counter wrapped.
    logic        targetFlag_q;  // Target reached.

    logic        decimalWrap;
    logic        fineMode;
    logic        clockOn;
    target_use_t targetUse;
    logic        wrCmd;
    logic        statRead;

    assign decimalWrap = control_q[CTL_DECIMAL_BIT];
    assign fineMode    = control_q[CTL_FINE_BIT];
    assign clockOn     = control_q[CTL_ENABLE_BIT];
    assign targetUse   = target_use_t'(control_q[CTL_USAGE_LSB +: 2]);
    assign wrCmd       = regWrite && (regAddr == REG_COMMAND);
    assign statRead    = regRead && (regAddr == REG_EVENT_STAT);

    // Plain configuration registers; the command register has no storage.
    always_ff @(posedge clk_sys or negedge rstSync_b) begin
        if (!rstSync_b) begin
            control_q <= 32'h0;
            operand_q <= '0;
            target_q  <= '0;
            subInc_q  <= SUB_INC_RESET;
            addend_q  <= ADDEND_RESET;
        end else if (regWrite) begin
            if (regAddr == REG_CONTROL) begin
                control_q <= regWrData;
            end else if (regAddr == REG_LOAD_SEC) begin
                operand_q.sec <= regWrData;
            end else if (regAddr == REG_LOAD_SUB) begin
                operand_q.sub <= regWrData;
            end else if (regAddr == REG_TARGET_SEC) begin
                target_q.sec <= regWrData;
            end else if (regAddr == REG_TARGET_SUB) begin
                target_q.sub <= regWrData;
            end else if (regAddr == REG_SUB_INC) begin
                subInc_q <= regWrData;
            end else if (regAddr == REG_ADDEND) begin
                addend_q <= regWrData;
            end
        end
    end

    // --------------------
    // Tick generation.
    // --------------------
    logic [31:0] accum_q;   // Fine update accumulator.
    logic [32:0] accumSum;  // Sum with carry out.
    logic        tick;      // One time step.

    assign accumSum = {1'b0, accum_q} + {1'b0, addend_q};

    // Coarse steps every clock; fine steps on accumulator carry.
    always_ff @(posedge clk_sys or negedge rstSync_b) begin
        if (!rstSync_b) begin
            accum_q <= 32'h0;
        end else if (clockOn && fineMode) begin
            accum_q <= accumSum[31:0];                      // [RULE16]
        end
    end

    assign tick = clockOn && (fineMode ? accumSum[32] : 1'b1); // [RULE16]

    // --------------------
    // Time counter.
    // --------------------
    sys_time_t   time_q;     // Running system time.
    sys_time_t   time_d;     // Next system time.
    logic [31:0] subLimit;   // Rollover point of the subsecond count.
    logic [32:0] subSum;     // Subseconds plus increment.
    logic [32:0] adjSub;     // Adjusted subseconds before correction.
    logic [31:0] adjSec;     // Adjusted seconds before borrow or carry.
    logic        secWrap;    // Seconds counter passes all ones.
    logic        secStep;    // A second boundary is crossed this cycle.

    // Decimal wrap counts nanoseconds; binary wrap counts 2^-31 s, about 0.46 ns.
    assign subLimit = decimalWrap ? NS_PER_SECOND                    // [RULE9]
                                  : 32'(64'h1 << BIN_SUB_BITS);      // [RULE10]
    assign subSum   = {1'b0, time_q.sub} + {1'b0, subInc_q};

    // Load wins over adjust, adjust over a tick; a load or adjust skips that tick.
    always_comb begin
        time_d  = time_q;
        secWrap = 1'b0;
        secStep = 1'b0;
        adjSub  = 33'h0;
        adjSec  = 32'h0;
        if (wrCmd && regWrData[CMD_LOAD_BIT]) begin
            time_d = operand_q;                                       // [RULE11]
        end else if (wrCmd && regWrData[CMD_ADJUST_BIT]) begin
            if (regWrData[CMD_DIR_BIT]) begin
                adjSub = {1'b0, time_q.sub} + {1'b0, operand_q.sub};  // [RULE12]
                adjSec = time_q.sec + operand_q.sec;
                if (adjSub >= {1'b0, subLimit}) begin
                    adjSub = adjSub - {1'b0, subLimit};
                    adjSec = adjSec + 32'h1;
                end
            end else begin
                adjSub = {1'b0, time_q.sub} - {1'b0, operand_q.sub};  // [RULE12]
                adjSec = time_q.sec - operand_q.sec;
                if (adjSub[32]) begin
                    adjSub = adjSub + {1'b0, subLimit};
                    adjSec = adjSec - 32'h1;
                end
            end
            time_d.sub = adjSub[31:0];
            time_d.sec = adjSec;
        end else if (tick) begin
            if (subSum >= {1'b0, subLimit}) begin
                time_d.sub = 32'(subSum - {1'b0, subLimit});          // [RULE18]
                time_d.sec = time_q.sec + 32'h1;
                secStep    = 1'b1;
                secWrap    = (time_q.sec == 32'hffffffff);
            end else begin
                time_d.sub = subSum[31:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstSync_b) begin
        if (!rstSync_b) begin
            time_q <= '0;
        end else begin
            time_q <= time_d;                                         // [RULE8]
        end
    end

    // ------------------------------------------------------------------
    // Target comparison.
    // ------------------------------------------------------------------
    logic reached;   // Time reaches target on this increment.
    logic useIrq;
    logic useCmd;

    assign reached = tick && !wrCmd && (time_d >= target_q) && !(time_q >= target_q);
    assign useIrq  = (targetUse != USE_CMD_ONLY);                     // [RULE17]
    assign useCmd  = (targetUse != USE_IRQ_ONLY);                     // [RULE17]

    // Arming is set by a command and ends when it fires or is disarmed.
    always_ff @(posedge clk_sys or negedge rstSync_b) begin
        if (!rstSync_b) begin
            armed_q <= 1'b0;
        end else if (wrCmd && regWrData[CMD_DISARM_BIT]) begin
            armed_q <= 1'b0;                                          // [RULE14]
        end else if (wrCmd && regWrData[CMD_WATCH_BIT]) begin
            armed_q <= 1'b1;
        end else if (reached && useIrq) begin
            armed_q <= 1'b0;
        end
    end

    // Flags: a set in the same cycle as the clearing read wins.
    always_ff @(posedge clk_sys or negedge rstSync_b) begin
        if (!rstSync_b) begin
            wrapFlag_q   <= 1'b0;
            targetFlag_q <= 1'b0;
        end else begin
            if (secWrap) begin
                wrapFlag_q <= 1'b1;
            end else if (statRead) begin
                wrapFlag_q <= 1'b0;                                   // [RULE15]
            end
            if (reached && armed_q && useIrq) begin
                targetFlag_q <= 1'b1;                                 // [RULE13]
            end else if (statRead) begin
                targetFlag_q <= 1'b0;                                 // [RULE15]
            end
        end
    end

    assign timeEventIrq = wrapFlag_q || targetFlag_q;

    // One-cycle strobe towards the command sequencer outside this block.
    always_ff @(posedge clk_sys or negedge rstSync_b) begin
        if (!rstSync_b) begin
            targetCmdTrigger <= 1'b0;
        end else begin
            targetCmdTrigger <= reached && useCmd;                    // [RULE17]
        end
    end

    // ------------------------------------------------------------------
    // Read data, valid the cycle after the strobe.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstSync_b) begin
        if (!rstSync_b) begin
            regRdData <= 32'h0;
        end else if (regRead) begin
            if (regAddr == REG_CONTROL) begin
                regRdData <= control_q;
            end else if (regAddr == REG_SECONDS) begin
                regRdData <= time_q.sec;                              // [RULE8]
            end else if (regAddr == REG_SUBSEC) begin
                regRdData <= time_q.sub;                              // [RULE8]
            end else if (regAddr == REG_LOAD_SEC) begin
                regRdData <= operand_q.sec;
            end else if (regAddr == REG_LOAD_SUB) begin
                regRdData <= operand_q.sub;
            end else if (regAddr == REG_TARGET_SEC) begin
                regRdData <= target_q.sec;
            end else if (regAddr == REG_TARGET_SUB) begin
                regRdData <= target_q.sub;
            end else if (regAddr == REG_SUB_INC) begin
                regRdData <= subInc_q;
            end else if (regAddr == REG_ADDEND) begin
                regRdData <= addend_q;
            end else if (regAddr == REG_EVENT_STAT) begin
                regRdData <= 32'h0;
                regRdData[STAT_WRAP_BIT]   <= wrapFlag_q;             // [RULE15]
                regRdData[STAT_TARGET_BIT] <= targetFlag_q;
            end else begin
                regRdData <= 32'h0;
            end
        end else begin
            regRdData <= 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // Pulse output.
    // ------------------------------------------------------------------
    pulse_freq_gen u_pulse (
        .clk_sys     (clk_sys),
        .rstSync_b   (rstSync_b),
        .subSec      (time_q.sub),
        .secStep     (secStep),
        .decimalWrap (decimalWrap),
        .freqSel     (control_q[CTL_FREQ_LSB +: 4]),
        .ppsOut      (ppsOut)
    );

endmodule : ptp_system_time_pps

/* include/ptp_time_pkg.sv */
// Package with the register map, field layouts and constants of the system time block.
package ptp_time_pkg;

    // --------------------
    // Register offsets (byte addresses on the plain register port).
    // --------------------
    localparam logic [7:0] REG_CONTROL    = 8'h00; // Mode and pulse settings.
    localparam logic [7:0] REG_SECONDS    = 8'h04; // Current seconds, read only.
    localparam logic [7:0] REG_SUBSEC     = 8'h08; // Current subseconds, read only.
    localparam logic [7:0] REG_LOAD_SEC   = 8'h0c; // Seconds operand for load or adjust.
    localparam logic [7:0] REG_LOAD_SUB   = 8'h10; // Subseconds operand for load or adjust.
    localparam logic [7:0] REG_COMMAND    = 8'h14; // Load, adjust, target enable and cancel.
    localparam logic [7:0] REG_TARGET_SEC = 8'h18; // Target seconds.
    localparam logic [7:0] REG_TARGET_SUB = 8'h1c; // Target subseconds.
    localparam logic [7:0] REG_SUB_INC    = 8'h20; // Subsecond increment per tick.
    localparam logic [7:0] REG_ADDEND     = 8'h24; // Fine update accumulator addend.
    localparam logic [7:0] REG_EVENT_STAT = 8'h28; // Event flags, cleared by reading.

    // --------------------
    // Control register fields.
    // --------------------
    localparam int CTL_DECIMAL_BIT = 0;  // High selects the decimal nanosecond wrap.
    localparam int CTL_FINE_BIT    = 1;  // High selects fine update through the addend.
    localparam int CTL_FREQ_LSB    = 4;  // Pulse frequency setting, four bits.
    localparam int CTL_USAGE_LSB   = 8;  // Target usage, two bits.
    localparam int CTL_ENABLE_BIT  = 12; // High lets the clock run.

    // Command register bits, each a self-clearing action except bit 2, which sets the adjust direction.
    localparam int CMD_LOAD_BIT   = 0;
    localparam int CMD_ADJUST_BIT = 1;
    localparam int CMD_DIR_BIT    = 2;   // High adds the interval, low subtracts it.
    localparam int CMD_WATCH_BIT  = 3;
    localparam int CMD_DISARM_BIT = 4;

    // Event status bits.
    localparam int STAT_WRAP_BIT   = 0;
    localparam int STAT_TARGET_BIT = 1;

    // --------------------
    // Pulse frequency settings and target usage codes.
    // --------------------
    localparam logic [3:0] FREQ_SINGLE  = 4'h0; // One pulse a second.
    localparam logic [3:0] FREQ_ONE_HZ  = 4'h1; // 1 Hz square wave.
    localparam logic [3:0] FREQ_TOP     = 4'hf; // 16384 Hz, power of two wrap only.

    typedef enum logic [1:0] {
        USE_IRQ_ONLY,
        USE_CMD_ONLY,
        USE_IRQ_AND_CMD
    } target_use_t;

    // --------------------
    // Time base constants.
    // --------------------
    localparam logic [31:0] NS_PER_SECOND   = 32'h3b9aca00; // One billion.
    localparam logic [31:0] SUB_INC_RESET   = 32'h00000028; // 40 ns at 25 MHz.
    localparam logic [31:0] ADDEND_RESET    = 32'h00000000;
    localparam int          BIN_SUB_BITS    = 31;           // Power of two wrap width.

    // A time value travels as one packed pair.
    typedef struct packed {
        logic [31:0] sec;
        logic [31:0] sub;
    } sys_time_t;

endpackage : ptp_time_pkg

/* rtl/pulse_freq_gen.sv */
// Pulse output generator driven by the running subsecond count.
`timescale 1ns/1ns
module pulse_freq_gen (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rstSync_b,
    // Time inputs.
    input  wire logic [31:0] subSec,
    input  wire logic        secStep,
    input  wire logic        decimalWrap,
    input  wire logic [3:0]  freqSel,
    // Pulse pin.
    output logic             ppsOut
);
    import ptp_time_pkg::*;

    // --------------------
    // Phase selection.
    // --------------------
    logic        phaseBit;   // Selected square wave level.
    logic [31:0] scaled;     // Subseconds mapped to a 31-bit binary fraction.
    logic        ppsOut_d;   // Next pulse level.

    // In the decimal wrap the nanosecond count is scaled to a binary fraction; the
    // truncation makes periods uneven, yet the average holds and each second realigns.
    always_comb begin
        if (decimalWrap) begin
            scaled = 32'(({32'h0, subSec} << BIN_SUB_BITS) / {32'h0, NS_PER_SECOND}); // [RULE7]
        end else begin
            scaled = subSec;
        end
        // Bit 30 toggles at 1 Hz, lower bits at higher powers of two.
        phaseBit = scaled[BIN_SUB_BITS - 32'(freqSel)];
    end

    always_comb begin
        if (freqSel == FREQ_SINGLE) begin
            ppsOut_d = secStep;                              // [RULE2]
        end else if (freqSel == FREQ_ONE_HZ && !decimalWrap) begin
            ppsOut_d = 1'b0;                                 // [RULE3]
        end else if (freqSel == FREQ_TOP && decimalWrap) begin
            ppsOut_d = 1'b0;                                 // [RULE5]
        end else begin
            ppsOut_d = ~phaseBit;                            // [RULE4] [RULE6]
        end
    end

    // The pin is registered so it carries no decode glitches.
    always_ff @(posedge clk_sys or negedge rstSync_b) begin
        if (!rstSync_b) begin
            ppsOut <= 1'b0;
        end else begin
            ppsOut <= ppsOut_d;                              // [RULE1]
        end
    end

endmodule : pulse_freq_gen

/* verification/ptp_system_time_pps_asserts.sv */
// Port-level checker for the system time block.
`timescale 1ns/1ns
module ptp_system_time_pps_asserts
    import ptp_time_pkg::*;
(
    // Clock and reset.
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // Register port.
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdData,
    // Event outputs and pulse pin.
    input wire logic        timeEventIrq,
    input wire logic        targetCmdTrigger,
    input wire logic        ppsOut
);
    // --------------------
    // Mirror of the control word, so mode checks know the setting.
    // --------------------
    logic [31:0] ctl_q; // Last control word written.
    logic [2:0]  age_q; // Cycles since that write, saturating at seven.
    logic        settled;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // The age lets the design's own registers catch up before a mode is judged.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctl_q <= 32'h0;
            age_q <= 3'h0;
        end else if (regWrite && regAddr == REG_CONTROL) begin
            ctl_q <= regWrData;
            age_q <= 3'h0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end
    assign settled = (age_q == 3'h7);
    // --------------------
    // Assertions.
    // --------------------
    a_read_idle_zero: assert property (!$past(regRead) |-> regRdData == 32'h0)
        else $error("read data seen outside a read answer");
    a_unmapped_read_zero: assert property ($past(regRead) && $past(regAddr) > REG_EVENT_STAT
        |-> regRdData == 32'h0) else $error("unmapped read not zero");
    a_trigger_one_cycle: assert property (targetCmdTrigger |=> !targetCmdTrigger)
        else $error("trigger longer than one cycle");
    a_trigger_needs_use: assert property (settled && targetCmdTrigger
        |-> ctl_q[CTL_USAGE_LSB +: 2] != USE_IRQ_ONLY) else $error("trigger in irq-only use");
    a_status_shows_irq: assert property (regRead && regAddr == REG_EVENT_STAT && timeEventIrq
        |=> regRdData[1:0] != 2'h0) else $error("status empty while irq high");
    a_single_one_clock: assert property (settled && ctl_q[CTL_FREQ_LSB +: 4] == FREQ_SINGLE
        && ppsOut |=> !ppsOut) else $error("single pulse wider than a clock");
    a_binary_onehz_off: assert property (settled && !ctl_q[CTL_DECIMAL_BIT]
        && ctl_q[CTL_FREQ_LSB +: 4] == FREQ_ONE_HZ |-> !ppsOut) else $error("1 Hz in binary");
    a_decimal_top_off: assert property (settled && ctl_q[CTL_DECIMAL_BIT]
        && ctl_q[CTL_FREQ_LSB +: 4] == FREQ_TOP |-> !ppsOut) else $error("top freq in decimal");
    c_pulse_rise: cover property ($rose(ppsOut));
    c_trigger: cover property (targetCmdTrigger);
    c_irq_rise: cover property ($rose(timeEventIrq));
endmodule : ptp_system_time_pps_asserts

bind ptp_system_time_pps ptp_system_time_pps_asserts chk (.clk_sys, .rst_b, .regAddr,
    .regWrData, .regWrite, .regRead, .regRdData, .timeEventIrq, .targetCmdTrigger, .ppsOut);

/* verification/ptp_system_time_pps_tb.sv */
// Self-checking bench for the system time block.
`timescale 1ns/1ns
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", what, exp, got); end end
module ptp_system_time_pps_tb;
    import ptp_time_pkg::*;
    logic        clk_sys;
    logic        rst_b;
    logic [7:0]  regAddr;
    logic [31:0] regWrData;
    logic        regWrite;
    logic        regRead;
    logic [31:0] regRdData;
    logic        timeEventIrq;
    logic        targetCmdTrigger;
    logic        ppsOut;
    logic [31:0] rd;     // Last word read.
    logic        early;  // Any event before the target could be reached.
    int          mismatches;
    int          tests_run;
    int          hi;     // Measured high and low times of the pulse pin.
    int          lo;
    int          trig;

    ptp_system_time_pps dut (.clk_sys, .rst_b, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData, .timeEventIrq, .targetCmdTrigger, .ppsOut);

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // --------------------
    // Register port tasks; each starts and ends just after a rising edge.
    // --------------------
    task wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task rdreg(input logic [7:0] a, output logic [31:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        d = regRdData;
        @(posedge clk_sys);
    endtask : rdreg
    task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        rdreg(a, d);
        `CHK(nm, e, d)
    endtask : rdchk
    // Writes the operand pair, then issues the given command.
    task op(input logic [31:0] s, input logic [31:0] ss, input logic [31:0] c);
        wr(REG_LOAD_SEC, s);
        wr(REG_LOAD_SUB, ss);
        wr(REG_COMMAND, c);
    endtask : op
    function automatic logic [31:0] ctl(logic dc, logic fn, logic [3:0] f, logic [1:0] u,
        logic en);
        return {19'h0, en, 2'h0, u, f, 2'h0, fn, dc};
    endfunction : ctl
    // Starts the pulse output from time zero, then times one high and one low phase.
    task ppscase(input logic dc, input logic [3:0] f, input logic [31:0] inc);
        int n;
        wr(REG_SUB_INC, inc);
        wr(REG_CONTROL, ctl(dc, 1'b0, f, 2'h0, 1'b1));
        op(32'h0, 32'h0, 32'h1);
        n = 0;
        hi = 0;
        lo = 0;
        while (ppsOut !== 1'b0 && n < 3000) begin @(negedge clk_sys); n++; end
        while (ppsOut !== 1'b1 && n < 3000) begin @(negedge clk_sys); n++; end
        while (ppsOut === 1'b1 && hi < 3000) begin @(negedge clk_sys); hi++; end
        while (ppsOut === 1'b0 && lo < 3000) begin @(negedge clk_sys); lo++; end
        @(posedge clk_sys);
    endtask : ppscase
    task automatic summarize;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // --------------------
    // Main sequence.
    // --------------------
    initial begin
        mismatches = 0;
        tests_run = 0;
        rst_b = 1'b0;
        regAddr = 8'h0;
        regWrData = 32'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdchk(REG_SUB_INC, SUB_INC_RESET, "increment");
        rdchk(REG_ADDEND, ADDEND_RESET, "addend");
        rdchk(8'h40, 32'h0, "unmapped");
        // Load and adjust with the clock stopped, so the time stays put.
        wr(REG_CONTROL, ctl(1'b1, 1'b0, FREQ_SINGLE, 2'h0, 1'b0));
        op(32'h5, 32'h64, 32'h1);
        rdchk(REG_SECONDS, 32'h5, "seconds");
        rdchk(REG_SUBSEC, 32'h64, "subseconds");
        op(32'h2, 32'h32, 32'h6);
        rdchk(REG_SECONDS, 32'h7, "sec added");
        rdchk(REG_SUBSEC, 32'h96, "sub added");
        op(32'h2, 32'h32, 32'h2);
        rdchk(REG_SUBSEC, 32'h64, "sub taken");
        // Reads two cycles apart: coarse gives two ticks, half-scale addend one.
        wr(REG_CONTROL, ctl(1'b1, 1'b0, FREQ_SINGLE, 2'h0, 1'b1));
        rdreg(REG_SUBSEC, rd);
        rdchk(REG_SUBSEC, rd + 32'd80, "coarse step");
        wr(REG_ADDEND, 32'h80000000);
        wr(REG_CONTROL, ctl(1'b1, 1'b1, FREQ_SINGLE, 2'h0, 1'b1));
        rdreg(REG_SUBSEC, rd);
        rdchk(REG_SUBSEC, rd + 32'd40, "fine step");
        // Decimal wrap just before the seconds count overflows.
        wr(REG_CONTROL, ctl(1'b1, 1'b0, FREQ_SINGLE, 2'h0, 1'b1));
        op(32'hffffffff, NS_PER_SECOND - 32'd400, 32'h1);
        repeat (30) @(posedge clk_sys);
        rdchk(REG_SECONDS, 32'h0, "dec wrap");
        rdreg(REG_EVENT_STAT, rd);
        `CHK("wrap flag", 1'b1, rd[STAT_WRAP_BIT])
        rdchk(REG_EVENT_STAT, 32'h0, "status cleared");
        `CHK("irq cleared", 1'b0, timeEventIrq)
        // Binary wrap at two to the power 31.
        wr(REG_CONTROL, ctl(1'b0, 1'b0, FREQ_SINGLE, 2'h0, 1'b1));
        op(32'h7, 32'h7ffffe70, 32'h1);
        repeat (30) @(posedge clk_sys);
        rdchk(REG_SECONDS, 32'h8, "bin wrap");
        rdreg(REG_EVENT_STAT, rd);
        // Target use: irq, command, both; the last pass enables, then cancels.
        for (int u = 0; u < 4; u++) begin
            wr(REG_CONTROL, ctl(1'b1, 1'b0, FREQ_SINGLE, (u == 3) ? 2'h0 : 2'(u), 1'b1));
            wr(REG_TARGET_SEC, 32'ha);
            wr(REG_TARGET_SUB, 32'hfa0);
            op(32'ha, 32'h0, 32'h1);
            wr(REG_COMMAND, 32'h8);
            if (u == 3) wr(REG_COMMAND, 32'h10);
            early = 1'b0;
            trig = 0;
            repeat (40) begin @(negedge clk_sys); early |= timeEventIrq | targetCmdTrigger; end
            repeat (150) begin @(negedge clk_sys); trig += int'(targetCmdTrigger); end
            `CHK("early", 1'b0, early)
            `CHK("irq", 1'((u == 0) || (u == 2)), timeEventIrq)
            `CHK("trigger", ((u == 1) || (u == 2)) ? 1 : 0, trig)
            @(posedge clk_sys);
            rdreg(REG_EVENT_STAT, rd);
            `CHK("target flag", 1'((u == 0) || (u == 2)), rd[STAT_TARGET_BIT])
        end
        // Pulse pin: binary settings 2 to 15 and decimal 1 to 6 give eight ticks per half period; single gives a one-tick pulse, barred settings stay low.
        for (int n = 2; n < 16; n++) begin
            ppscase(1'b0, 4'(n), 32'h1 << (28 - n));
            `CHK("even duty", lo, hi)
            `CHK("bin half", 8, hi)
        end
        for (int n = 1; n < 7; n++) begin
            ppscase(1'b1, 4'(n), NS_PER_SECOND >> (n + 3));
            `CHK("dec high", 8, hi)
            `CHK("dec low", 8, lo)
        end
        ppscase(1'b1, FREQ_SINGLE, NS_PER_SECOND >> 4);
        `CHK("pulse width", 1, hi)
        `CHK("pulse gap", 15, lo)
        for (int k = 0; k < 2; k++) begin
            wr(REG_CONTROL, ctl(k[0], 1'b0, k[0] ? FREQ_TOP : FREQ_ONE_HZ, 2'h0, 1'b1));
            early = 1'b0;
            repeat (60) begin @(negedge clk_sys); early |= ppsOut; end
            `CHK("barred setting", 1'b0, early)
            @(posedge clk_sys);
        end
        summarize();
    end
    // Cuts a hang short well beyond the few thousand cycles the tests need.
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        summarize();
    end
endmodule : ptp_system_time_pps_tb
